// [hdl/pgen_pkg.sv]
`default_nettype none

package pgen_pkg;

   // Bus and data widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 11;

   // Register offsets (I/O addresses)
   localparam logic [7:0] ADDR_CONTROL = 8'h20;
   localparam logic [7:0] ADDR_SCALER = 8'h21;
   localparam logic [7:0] ADDR_DUTY_HIGH = 8'h22;
   localparam logic [7:0] ADDR_DUTY_LOW = 8'h23;
   localparam logic [7:0] ADDR_BOUND_HIGH = 8'h24;
   localparam logic [7:0] ADDR_BOUND_LOW = 8'h25;

   // Control register field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 6;
   localparam int CTRL_INV_BIT = 5;
   localparam int CTRL_CLR_BIT = 4;
   localparam int CTRL_ROUTE_MSB = 3;
   localparam int CTRL_ROUTE_LSB = 1;
   localparam int CTRL_CLKSEL_BIT = 0;

   // Scaler register field positions
   localparam int SCL_INTMODE_BIT = 7;
   localparam int SCL_PRE_MSB = 6;
   localparam int SCL_PRE_LSB = 5;
   localparam int SCL_DIV_MSB = 4;
   localparam int SCL_DIV_LSB = 0;

   // Low byte field positions of bound and duty
   localparam int BOUND_LO_MSB = 7;
   localparam int BOUND_LO_LSB = 6;
   localparam int DUTY_LO_MSB = 7;
   localparam int DUTY_LO_LSB = 5;

   // Bound bit 0 has no register bit behind it
   localparam logic BOUND_BIT0 = 1'b1;

   // Output routing codes
   localparam logic [2:0] ROUTE_NONE = 3'h0;
   localparam logic [2:0] ROUTE_PIN0 = 3'h1;
   localparam logic [2:0] ROUTE_PIN1 = 3'h3;
   localparam logic [2:0] ROUTE_PIN2 = 3'h4;
   localparam int NUM_PINS = 3;

   // Prescaler terminal counts for codes 00..11 (divide by 1, 4, 16, 64)
   localparam logic [5:0] PRE_MAX_1 = 6'h00;
   localparam logic [5:0] PRE_MAX_4 = 6'h03;
   localparam logic [5:0] PRE_MAX_16 = 6'h0f;
   localparam logic [5:0] PRE_MAX_64 = 6'h3f;

   // Interrupt condition modes
   localparam logic INT_ON_DUTY = 1'b0;
   localparam logic INT_ON_ZERO = 1'b1;

   // Clock source choices
   localparam logic SRC_SYSTEM = 1'b0;
   localparam logic SRC_FAST_OSC = 1'b1;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic we;
      logic re;
   } pgen_bus_req_t;

   // Whole state of the generator
   typedef struct packed {
      logic ctrl_en;
      logic ctrl_inv;
      logic clr_req;
      logic [2:0] route;
      logic clk_sel;
      logic int_mode;
      logic [1:0] pre_code;
      logic [4:0] div_val;
      logic [7:0] bound_hi;
      logic [1:0] bound_lo;
      logic [CNT_W-1:0] duty;
      logic [2:0] duty_lo_pend;
      logic osc_s1;
      logic osc_s2;
      logic osc_s3;
      logic osc_lvl;
      logic [5:0] pre_cnt;
      logic [4:0] div_cnt;
      logic [CNT_W-1:0] cnt;
      logic gen_out;
      logic [NUM_PINS-1:0] pins;
      logic irq;
      logic [DATA_W-1:0] rdata;
   } pgen_state_t;

endpackage

`default_nettype wire

// [hdl/pgen_top.sv]
// Design decision made here: the address-and-strobe port.
`default_nettype none


module pgen_top #(
   parameter bit FAST_DOUBLE = 1'b0
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Register port
   input wire pgen_pkg::pgen_bus_req_t i_bus,
   output logic [pgen_pkg::DATA_W-1:0] o_rdata,
   // Fast oscillator pin
   input wire logic i_fast_osc,
   // Port pins and event
   output logic [pgen_pkg::NUM_PINS-1:0] o_pins,
   output logic o_int_event
);
   import pgen_pkg::*;

   // Current and next state
   pgen_state_t s_q;
   pgen_state_t s_d;

   // Prescaler terminal count for a scaler code
   function automatic logic [5:0] pre_max(input logic [1:0] code);
      logic [5:0] m;
      m = PRE_MAX_1;
      unique case (code)
         2'h0: begin
            m = PRE_MAX_1;
         end
         2'h1: begin
            m = PRE_MAX_4;
         end
         2'h2: begin
            m = PRE_MAX_16;
         end
         2'h3: begin
            m = PRE_MAX_64;
         end
      endcase
      return m;
   endfunction

   // Route code that selects a given pin
   function automatic logic [2:0] pin_code(input int idx);
      logic [2:0] c;
      c = ROUTE_PIN0;
      if (idx == 1) begin
         c = ROUTE_PIN1;
      end else if (idx == 2) begin
         c = ROUTE_PIN2;
      end
      return c;
   endfunction

   // Working signals of the next-state logic
   logic src_tick;  // Tick from the chosen clock source
   logic osc_edge;  // Filtered oscillator change
   logic pre_tick;  // Prescaler output tick
   logic cnt_tick;  // Divider output tick, advances the counter
   logic [CNT_W-1:0] bound;  // Full counter upper bound
   logic [CNT_W-1:0] cnt_nx;  // Counter after this cycle
   logic gen_lvl;  // Generator level before inversion
   logic pin_lvl;  // Level after optional inversion
   logic wr_ctrl;
   logic wr_scl;

   // Next-state logic
   always_comb begin
      s_d = s_q;
      src_tick = 1'b0;
      osc_edge = 1'b0;
      pre_tick = 1'b0;
      cnt_tick = 1'b0;
      cnt_nx = s_q.cnt;
      gen_lvl = 1'b0;
      pin_lvl = 1'b0;
      wr_ctrl = i_bus.we && (i_bus.addr == ADDR_CONTROL);
      wr_scl = i_bus.we && (i_bus.addr == ADDR_SCALER);
      bound = {s_q.bound_hi, s_q.bound_lo, BOUND_BIT0};

      // Oscillator pin synchroniser, three stages
      s_d.osc_s1 = i_fast_osc;
      s_d.osc_s2 = s_q.osc_s1;
      s_d.osc_s3 = s_q.osc_s2;
      // A change counts once stages two and three agree
      if ((s_q.osc_s2 == s_q.osc_s3) && (s_q.osc_s3 != s_q.osc_lvl)) begin
         s_d.osc_lvl = s_q.osc_s3;
         osc_edge = 1'b1;
      end

      // Clock source choice
      if (s_q.clk_sel == SRC_SYSTEM) begin
         src_tick = 1'b1;
      end else if (FAST_DOUBLE) begin
         // Both oscillator edges: twice the oscillator rate
         src_tick = osc_edge;
      end else begin
         // Rising oscillator edges only
         src_tick = osc_edge && s_q.osc_s3;
      end

      // Prescaler then 5-bit divider
      if (!s_q.ctrl_en) begin
         s_d.pre_cnt = '0;
         s_d.div_cnt = '0;
      end else if (src_tick) begin
         if (s_q.pre_cnt >= pre_max(s_q.pre_code)) begin
            s_d.pre_cnt = '0;
            pre_tick = 1'b1;
         end else begin
            s_d.pre_cnt = s_q.pre_cnt + 6'h01;
         end
      end
      if (s_q.ctrl_en && pre_tick) begin
         // Divide by divider value plus one
         if (s_q.div_cnt >= s_q.div_val) begin
            s_d.div_cnt = '0;
            cnt_tick = 1'b1;
         end else begin
            s_d.div_cnt = s_q.div_cnt + 5'h01;
         end
      end

      // Counter: software clear, held at zero when off, else count and wrap
      if (s_q.clr_req) begin
         cnt_nx = '0;
      end else if (!s_q.ctrl_en) begin
         cnt_nx = '0;
      end else if (cnt_tick) begin
         if (s_q.cnt >= bound) begin
            cnt_nx = '0;
         end else begin
            cnt_nx = s_q.cnt + 11'h001;
         end
      end
      s_d.cnt = cnt_nx;
      // Clear request drops once the counter has been cleared
      s_d.clr_req = 1'b0;

      // Event on the chosen condition, on a counter step or clear
      s_d.irq = 1'b0;
      if (s_q.ctrl_en && (cnt_tick || s_q.clr_req)) begin
         if (s_q.int_mode == INT_ON_ZERO) begin
            s_d.irq = (cnt_nx == '0);
         end else begin
            s_d.irq = (cnt_nx == s_q.duty);
         end
      end

      // Output high while counter below duty, only when running
      gen_lvl = s_q.ctrl_en && (cnt_nx < s_q.duty);
      s_d.gen_out = gen_lvl;
      pin_lvl = gen_lvl ^ s_q.ctrl_inv;

      // Route to one pin; other pins and reserved codes stay low
      for (int i = 0; i < NUM_PINS; i++) begin
         s_d.pins[i] = (s_q.route == pin_code(i)) && pin_lvl;
      end

      // Control register write
      if (wr_ctrl) begin
         s_d.ctrl_en = i_bus.wdata[CTRL_EN_BIT];
         s_d.ctrl_inv = i_bus.wdata[CTRL_INV_BIT];
         s_d.clr_req = i_bus.wdata[CTRL_CLR_BIT];
         s_d.route = i_bus.wdata[CTRL_ROUTE_MSB:CTRL_ROUTE_LSB];
         s_d.clk_sel = i_bus.wdata[CTRL_CLKSEL_BIT];
      end

      // Scaler register write
      if (wr_scl) begin
         s_d.int_mode = i_bus.wdata[SCL_INTMODE_BIT];
         s_d.pre_code = i_bus.wdata[SCL_PRE_MSB:SCL_PRE_LSB];
         s_d.div_val = i_bus.wdata[SCL_DIV_MSB:SCL_DIV_LSB];
      end

      // Bound registers
      if (i_bus.we && (i_bus.addr == ADDR_BOUND_HIGH)) begin
         s_d.bound_hi = i_bus.wdata;
      end
      if (i_bus.we && (i_bus.addr == ADDR_BOUND_LOW)) begin
         s_d.bound_lo = i_bus.wdata[BOUND_LO_MSB:BOUND_LO_LSB];
      end

      // Duty low waits; duty high applies the whole value
      if (i_bus.we && (i_bus.addr == ADDR_DUTY_LOW)) begin
         s_d.duty_lo_pend = i_bus.wdata[DUTY_LO_MSB:DUTY_LO_LSB];
      end
      if (i_bus.we && (i_bus.addr == ADDR_DUTY_HIGH)) begin
         s_d.duty = {i_bus.wdata, s_q.duty_lo_pend};
      end

      // Read data for one cycle only; write-only registers read zero
      s_d.rdata = '0;
      if (i_bus.re && (i_bus.addr == ADDR_CONTROL)) begin
         s_d.rdata[CTRL_EN_BIT] = s_q.ctrl_en;
         s_d.rdata[CTRL_OUT_BIT] = s_q.gen_out;
         s_d.rdata[CTRL_INV_BIT] = s_q.ctrl_inv;
         s_d.rdata[CTRL_CLR_BIT] = s_q.clr_req;
         s_d.rdata[CTRL_ROUTE_MSB:CTRL_ROUTE_LSB] = s_q.route;
         s_d.rdata[CTRL_CLKSEL_BIT] = s_q.clk_sel;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_rdata = s_q.rdata;
   assign o_pins = s_q.pins;
   assign o_int_event = s_q.irq;

endmodule

`default_nettype wire

// [sim/pgen_chk.sv]
`default_nettype none
module pgen_chk (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Watched ports
   input wire pgen_pkg::pgen_bus_req_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic i_fast_osc,
   input wire logic [2:0] o_pins,
   input wire logic o_int_event
);
   import pgen_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // Shadows of control and scaler, cycles since a control write
   logic [7:0] ctrl_q, scl_q, vis;
   logic [1:0] quiet_q;
   logic wr_c;
   assign wr_c = i_bus.we && i_bus.addr == ADDR_CONTROL;
   // Control bits that read back as written
   assign vis = ctrl_q & 8'haf;
   // Follow register writes
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= 8'h00;
         scl_q <= 8'h00;
         quiet_q <= 2'h0;
      end else begin
         if (wr_c) ctrl_q <= i_bus.wdata;
         if (i_bus.we && i_bus.addr == ADDR_SCALER) scl_q <= i_bus.wdata;
         quiet_q <= wr_c ? 2'h0 : quiet_q + 2'(quiet_q != 2'h3);
      end
   end
   // Pin image of a disabled generator
   function automatic logic [2:0] pmap(input logic [7:0] c);
      return c[3:1] == ROUTE_PIN0 ? {2'h0, c[5]} : c[3:1] == ROUTE_PIN1 ?
         {1'h0, c[5], 1'h0} : c[3:1] == ROUTE_PIN2 ? {c[5], 2'h0} : 3'h0;
   endfunction
   rd_zero_a: assert property (
      !$past(i_bus.re) || $past(i_bus.addr) != ADDR_CONTROL |-> o_rdata == 8'h00)
      else $error("stray read data");
   pin_one_a: assert property ($onehot0(o_pins))
      else $error("several pins driven");
   off_no_evt_a: assert property (
      !ctrl_q[7] && !$past(ctrl_q[7]) |-> !o_int_event) else $error("event while off");
   off_pin_lvl_a: assert property (
      quiet_q == 2'h3 && !ctrl_q[7] |-> o_pins == pmap(ctrl_q)) else $error("idle pin level");
   no_route_a: assert property (
      quiet_q == 2'h3 && ctrl_q[3:1] == ROUTE_NONE |-> o_pins == 3'h0)
      else $error("pin without route");
   ctrl_read_a: assert property (
      $past(i_bus.re) && $past(i_bus.addr) == ADDR_CONTROL |-> (o_rdata & 8'haf) == $past(vis))
      else $error("control readback");
   clr_evt_a: assert property (
      wr_c && i_bus.wdata[7] && i_bus.wdata[4] && ctrl_q[7] && scl_q[7] |-> ##[1:3] o_int_event)
      else $error("no event after clear");
   out_level_a: assert property (
      $past(i_bus.re) && $past(i_bus.addr) == ADDR_CONTROL && quiet_q == 2'h3 &&
      ctrl_q[3:1] == ROUTE_PIN0 |-> o_rdata[6] == ($past(o_pins[0]) ^ ctrl_q[5]))
      else $error("output level readback");
   clr_bit_a: assert property (
      $past(i_bus.re) && $past(i_bus.addr) == ADDR_CONTROL && !$past(wr_c, 2) |-> !o_rdata[4])
      else $error("clear bit stuck");
   // Main scenarios reached
   cover property (o_int_event);
   cover property (quiet_q == 2'h3 && ctrl_q[7] && o_pins[0]);
   cover property ($past(i_bus.re) && o_rdata[4]);
endmodule
bind pgen_top pgen_chk u_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_bus(i_bus),
   .o_rdata(o_rdata), .i_fast_osc(i_fast_osc), .o_pins(o_pins), .o_int_event(o_int_event));
`default_nettype wire

// [sim/tb_pgen_top.sv]
`default_nettype none
module tb_pgen_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pgen_pkg::*;
   // Stimulus, outputs, counters
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   pgen_bus_req_t bus = '0;
   logic [2:0] osc = 3'h0;
   logic [7:0] rdata;
   logic [2:0] pins;
   logic evt;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h2, 3'h7};
   pgen_top #(.FAST_DOUBLE(1'b0)) DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_bus(bus),
      .o_rdata(rdata), .i_fast_osc(osc[2]), .o_pins(pins), .o_int_event(evt));
   // 25 MHz clock
   always #20 i_clk_sys = ~i_clk_sys;
   // Oscillator at an eighth of the clock, hang limit
   always @(posedge i_clk_sys) begin
      osc <= osc + 3'h1;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge i_clk_sys);
   endtask
   task automatic idle(input int n);
      bus <= '0;
      repeat (n) @(posedge i_clk_sys);
   endtask
   // Read, compare the masked data in the following cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge i_clk_sys);
      bus <= '0;
      @(negedge i_clk_sys);
      cmp({8'h00, rdata & m}, {8'h00, e & m});
      @(posedge i_clk_sys);
   endtask
   function automatic logic [2:0] pmap(input logic [7:0] c);
      return c[3:1] == 3'h1 ? {2'h0, c[5]} : c[3:1] == 3'h3 ? {1'h0, c[5], 1'h0} :
         c[3:1] == 3'h4 ? {c[5], 2'h0} : 3'h0;
   endfunction
   // High counter values per period
   function automatic int lvl(input int d, input int b);
      return d <= b ? d : b + 1;
   endfunction
   initial begin
      logic [7:0] c;
      int pre, dv, bh, bl, bd, dt, u, hi, ev, inv, md;
      void'($urandom(32'hb000));
      repeat (3) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      // Disabled: route codes 0, 1, 2, 3, 4 and 7, both polarities
      for (int k = 0; k < 12; k++) begin
         c = {2'h0, 1'(k % 2), 1'b0, codes[k / 2], 1'($urandom_range(1))};
         wr(ADDR_CONTROL, c);
         idle(4);
         @(negedge i_clk_sys);
         cmp(16'(pins), 16'(pmap(c)));
         @(posedge i_clk_sys);
         rd(ADDR_CONTROL, c, 8'hff);
      end
      for (int a = 8'h21; a < 8'h27; a++) rd(8'(a), 8'h00, 8'hff);
      // Counting: each prescale code, both sources and modes
      for (int i = 0; i < 8; i++) begin
         pre = i % 4;
         md = i / 2 % 2;
         dv = pre < 2 ? $urandom_range(3) : 0;
         bh = pre < 2 ? $urandom_range(1) : 0;
         bl = $urandom_range(3);
         bd = bh * 8 + bl * 2 + 1;
         dt = $urandom_range(bd + 2);
         inv = $urandom_range(1);
         u = (1 << 2 * pre) * (dv + 1) * (i < 4 ? 1 : 8);
         c = 8'h82 + 8'(inv * 32 + i / 4);
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_SCALER, {1'(md), 2'(pre), 5'(dv)});
         wr(ADDR_BOUND_LOW, {2'(bl), 6'h00});
         wr(ADDR_BOUND_HIGH, 8'(bh));
         wr(ADDR_DUTY_LOW, {3'(dt), 5'h00});
         wr(ADDR_DUTY_HIGH, 8'(dt >> 3));
         wr(ADDR_DUTY_LOW, 8'($urandom));
         wr(ADDR_CONTROL, c);
         idle((bd + 1) * u + 12);
         hi = 0;
         ev = 0;
         repeat (2 * (bd + 1) * u) begin
            @(negedge i_clk_sys);
            hi += int'(pins[0] === 1'b1);
            ev += int'(evt === 1'b1);
         end
         @(posedge i_clk_sys);
         cmp(16'(hi), 16'(2 * u * (inv ? bd + 1 - lvl(dt, bd) : lvl(dt, bd))));
         cmp(16'(ev), 16'(md || dt <= bd ? 2 : 0));
         rd(ADDR_CONTROL, c, 8'hbf);
         wr(ADDR_CONTROL, c | 8'h10);
         rd(ADDR_CONTROL, c | 8'h10, 8'hbf);
         rd(ADDR_CONTROL, c, 8'hbf);
      end
      idle(2);
      stop_test();
   end
endmodule
`default_nettype wire
